// >>> include/wdog_map.svh
// register map, codes and timing for the process data watchdog block
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH
`define TIMEOUT_ADDR 16'h07d0
`define MODE_ADDR 16'h07d2
`define REASON_ADDR 16'h07d4
`define CMD_ADDR 16'h07d6
`define STATUS_ADDR 16'h1f3c
`define DIAG_ADDR 16'h1f3d
`define TIMEOUT_RESET 16'h0000
`define TIMEOUT_MIN 16'h00c8
`define TIMEOUT_MAX 16'hfde8
`define MODE_RESET 2'h0
`define MODE_LOW 2'h0
`define MODE_HIGH 2'h1
`define MODE_HOLD 2'h2
`define REASON_RESET 16'h0000
`define REASON_LINK 16'h0007
`define REASON_HOST 16'h0008
`define REASON_USER 16'h0009
`define REASON_ABORT 16'h000a
`define REASON_INIT 16'h000b
`define REASON_WDOG 16'h000c
`define REASON_CONN 16'h000d
`define CMD_SET_BIT 4
`define CMD_ACK_BIT 5
`define CMD_CLR_BIT 7
`define ST_ERROR_BIT 0
`define ST_FAIL_BIT 1
`define DG_OUT_SHORT_BIT 0
`define DG_UNDERVOLT_BIT 2
`define DG_SURGE_BIT 3
`define DG_SENS_SHORT_BIT 4
`define DG_OVERTEMP_BIT 10
`define CLK_PERIOD_NS 10
`define MS_PERIOD_NS 1000000
`define CYCLES_PER_MS (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// >>> include/wdog_pkg.sv
// types shared by the process data watchdog files
package wdog_pkg;
  typedef enum logic [1:0] {WD_OFF, WD_ARMED, WD_RUN} wd_state_t;
  typedef logic [1:0] fault_mode_t;
endpackage

// >>> verilog/ms_tick.sv
// millisecond time base with restart
`timescale 1ns/1ps
module ms_tick #(
  parameter int CYCLES = 100000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  output logic tick
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt_reg;
  logic tick_reg;

  generate
    if (CYCLES < 2) begin : g_chk
      $error("ms_tick needs at least two cycles per tick");
    end
  endgenerate

  // restart aligns the first tick one full period after clr
  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      cnt_reg <= '0;
    end else if (cnt_reg == W'(CYCLES - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == W'(CYCLES - 1));
    end
  end

  assign tick = tick_reg;
endmodule

// >>> verilog/process_watchdog.sv
// output data watchdog, substitute values and fault registers
`timescale 1ns/1ps
`include "wdog_map.svh"
module process_watchdog #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter int OUT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic reg_ack,
  output logic [15:0] reg_rdata,
  output logic reg_exc,
  input wire logic pd_wr,
  input wire logic [OUT_WIDTH-1:0] pd_wdata,
  input wire logic ack_manual,
  input wire logic conn_timeout,
  input wire logic conn_abort,
  input wire logic init_error,
  input wire logic internal_link_timeout,
  input wire logic host_timeout,
  input wire logic out_overload_pin,
  input wire logic sens_undervolt_pin,
  input wire logic sens_surge_pin,
  input wire logic sens_short_pin,
  input wire logic over_temp_pin,
  output logic [OUT_WIDTH-1:0] dout,
  output logic net_fail,
  output logic cmd_error
);
  generate
    if (OUT_WIDTH < 1 || OUT_WIDTH > 16) begin : g_chk
      $error("OUT_WIDTH must lie between 1 and 16");
    end
  endgenerate

  logic [15:0] timeout_reg;
  wdog_pkg::fault_mode_t mode_reg;
  logic [15:0] reason_reg;
  logic net_fail_reg;
  logic [OUT_WIDTH-1:0] pd_reg;
  logic [OUT_WIDTH-1:0] dout_reg;
  logic [15:0] elapsed_reg;
  wdog_pkg::wd_state_t wd_state_reg;
  logic [2:0] diag_latch_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic reg_ack_reg;
  logic [15:0] reg_rdata_reg;
  logic reg_exc_reg;
  logic cmd_error_reg;

  // bus decode
  logic wr, rd, hit_to, hit_mode, hit_reason, hit_cmd, hit_st, hit_dg;
  logic active, to_ok, mode_ok, to_wr, mode_wr;
  logic cmd_wr, cmd_one, cmd_bad, cmd_set, cmd_ack, cmd_clr;
  logic exc_next;
  assign wr = reg_req & reg_we;
  assign rd = reg_req & ~reg_we;
  assign hit_to = (reg_addr == `TIMEOUT_ADDR);
  assign hit_mode = (reg_addr == `MODE_ADDR);
  assign hit_reason = (reg_addr == `REASON_ADDR);
  assign hit_cmd = (reg_addr == `CMD_ADDR);
  assign hit_st = (reg_addr == `STATUS_ADDR);
  assign hit_dg = (reg_addr == `DIAG_ADDR);
  assign active = (wd_state_reg == wdog_pkg::WD_RUN);
  // zero refused once running: supervision cannot be switched off
  assign to_ok = (reg_wdata == 16'h0000) ? !active :
                 (reg_wdata >= `TIMEOUT_MIN &&
                  reg_wdata <= `TIMEOUT_MAX);
  assign mode_ok = (reg_wdata <= {14'h0000, `MODE_HOLD});
  assign to_wr = wr & hit_to & to_ok;
  assign mode_wr = wr & hit_mode & mode_ok;
  assign cmd_wr = wr & hit_cmd;
  assign cmd_one = (reg_wdata != 16'h0000) &&
                   ((reg_wdata & (reg_wdata - 16'h0001)) == 16'h0000);
  assign cmd_bad = cmd_wr & ~cmd_one;
  assign cmd_set = cmd_wr & cmd_one & reg_wdata[`CMD_SET_BIT];
  assign cmd_ack = cmd_wr & cmd_one & reg_wdata[`CMD_ACK_BIT];
  assign cmd_clr = cmd_wr & cmd_one & reg_wdata[`CMD_CLR_BIT];

  always_comb begin
    exc_next = 1'b0;
    if (wr) begin
      exc_next = !(to_wr || mode_wr || (cmd_wr && cmd_one));
    end else if (rd) begin
      exc_next = !(hit_to || hit_mode || hit_reason || hit_st || hit_dg);
    end
  end

  // diagnostic pins cross from the outside world
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end else begin
      pin_s1_reg <= {over_temp_pin, sens_short_pin, sens_surge_pin,
                     sens_undervolt_pin, out_overload_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // latched events: a new event in the clear cycle survives
  always_ff @(posedge clk) begin
    if (!resetn) begin
      diag_latch_reg <= 3'h0;
    end else begin
      diag_latch_reg <= (cmd_clr ? 3'h0 : diag_latch_reg) |
                        {pin_s2_reg[3], pin_s2_reg[2], pin_s2_reg[0]};
    end
  end

  logic [15:0] diag_status, summary_status;
  always_comb begin
    diag_status = 16'h0000;
    diag_status[`DG_OUT_SHORT_BIT] = diag_latch_reg[0];
    diag_status[`DG_UNDERVOLT_BIT] = pin_s2_reg[1];
    diag_status[`DG_SURGE_BIT] = diag_latch_reg[1];
    diag_status[`DG_SENS_SHORT_BIT] = diag_latch_reg[2];
    diag_status[`DG_OVERTEMP_BIT] = pin_s2_reg[4];
    summary_status = 16'h0000;
    summary_status[`ST_ERROR_BIT] = net_fail_reg ||
                                    (diag_status != 16'h0000);
    summary_status[`ST_FAIL_BIT] = net_fail_reg;
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timeout_reg <= `TIMEOUT_RESET;
    end else if (to_wr) begin
      timeout_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_reg <= `MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= reg_wdata[1:0];
    end
  end

  // watchdog
  logic tick, ack_fire, restart, expire, fail_any;
  assign ack_fire = net_fail_reg &
                    (cmd_ack | (~ack_manual & pd_wr));
  assign restart = (active & pd_wr) | ack_fire;
  assign expire = active & ~net_fail_reg & tick & ~restart &
                  ({1'b0, elapsed_reg} + 17'h00001 >=
                   {1'b0, timeout_reg});

  ms_tick #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .clk(clk),
    .resetn(resetn),
    .clr(restart),
    .tick(tick)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wd_state_reg <= wdog_pkg::WD_OFF;
    end else begin
      case (wd_state_reg)
        wdog_pkg::WD_OFF: begin
          if (timeout_reg != 16'h0000) begin
            wd_state_reg <= wdog_pkg::WD_ARMED;
          end
        end
        wdog_pkg::WD_ARMED: begin
          if (timeout_reg == 16'h0000) begin
            wd_state_reg <= wdog_pkg::WD_OFF;
          end else if (pd_wr) begin
            wd_state_reg <= wdog_pkg::WD_RUN;
          end
        end
        wdog_pkg::WD_RUN: begin
          wd_state_reg <= wdog_pkg::WD_RUN;
        end
        default: begin
          wd_state_reg <= wdog_pkg::WD_OFF;
        end
      endcase
    end
  end

  // counting pauses while failed; the acknowledge starts a fresh period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      elapsed_reg <= 16'h0000;
    end else if (restart || !active) begin
      elapsed_reg <= 16'h0000;
    end else if (tick && !net_fail_reg && elapsed_reg != 16'hffff) begin
      elapsed_reg <= elapsed_reg + 16'h0001;
    end
  end

  // failure indication: a new failure wins over an acknowledge
  assign fail_any = expire | cmd_set | conn_timeout | conn_abort |
                    init_error | internal_link_timeout | host_timeout;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      net_fail_reg <= 1'b0;
    end else if (fail_any) begin
      net_fail_reg <= 1'b1;
    end else if (ack_fire) begin
      net_fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reason_reg <= `REASON_RESET;
    end else if (expire) begin
      reason_reg <= `REASON_WDOG;
    end else if (cmd_set) begin
      reason_reg <= `REASON_USER;
    end else if (conn_timeout) begin
      reason_reg <= `REASON_CONN;
    end else if (conn_abort) begin
      reason_reg <= `REASON_ABORT;
    end else if (init_error) begin
      reason_reg <= `REASON_INIT;
    end else if (internal_link_timeout) begin
      reason_reg <= `REASON_LINK;
    end else if (host_timeout) begin
      reason_reg <= `REASON_HOST;
    end
  end

  // outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pd_reg <= '0;
    end else if (pd_wr) begin
      pd_reg <= pd_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout_reg <= '0;
    end else if (net_fail_reg) begin
      case (mode_reg)
        `MODE_LOW: dout_reg <= '0;
        `MODE_HIGH: dout_reg <= '1;
        default: dout_reg <= dout_reg;
      endcase
    end else begin
      dout_reg <= pd_reg;
    end
  end

  // register answers, one cycle after the request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_ack_reg <= 1'b0;
      reg_exc_reg <= 1'b0;
      cmd_error_reg <= 1'b0;
    end else begin
      reg_ack_reg <= reg_req;
      reg_exc_reg <= exc_next;
      cmd_error_reg <= cmd_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata_reg <= 16'h0000;
    end else if (rd) begin
      if (hit_to) begin
        reg_rdata_reg <= timeout_reg;
      end else if (hit_mode) begin
        reg_rdata_reg <= {14'h0000, mode_reg};
      end else if (hit_reason) begin
        reg_rdata_reg <= reason_reg;
      end else if (hit_st) begin
        reg_rdata_reg <= summary_status;
      end else if (hit_dg) begin
        reg_rdata_reg <= diag_status;
      end else begin
        reg_rdata_reg <= 16'h0000;
      end
    end
  end

  assign reg_ack = reg_ack_reg;
  assign reg_rdata = reg_rdata_reg;
  assign reg_exc = reg_exc_reg;
  assign dout = dout_reg;
  assign net_fail = net_fail_reg;
  assign cmd_error = cmd_error_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_cmd(int b);
    cmd_wr && reg_wdata == (16'h0001 << b);
  endsequence

  property p_zero_off;
    (timeout_reg == 16'h0000 && !active) |-> !expire;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("watchdog expired while disabled");

  property p_subst_low;
    (net_fail_reg && mode_reg == `MODE_LOW) |=> dout_reg == '0;
  endproperty
  a_subst_low: assert property (p_subst_low)
    else $error("outputs not low under failure");

  property p_subst_hold;
    (net_fail_reg && mode_reg == `MODE_HOLD) |=> $stable(dout_reg);
  endproperty
  a_subst_hold: assert property (p_subst_hold)
    else $error("outputs not held under failure");

  property p_wd_reason;
    expire |=> net_fail_reg && reason_reg == `REASON_WDOG
               && summary_status[`ST_FAIL_BIT];
  endproperty
  a_wd_reason: assert property (p_wd_reason)
    else $error("expiry not reported");

  property p_multi_cmd;
    (cmd_wr && !cmd_one && !fail_any) |=>
      cmd_error && reg_exc && $stable(net_fail_reg);
  endproperty
  a_multi_cmd: assert property (p_multi_cmd)
    else $error("bad command word not refused");

  property p_cmd_read;
    (rd && hit_cmd) |=> reg_exc && reg_rdata == 16'h0000;
  endproperty
  a_cmd_read: assert property (p_cmd_read)
    else $error("command register readable");

  property p_force;
    s_cmd(`CMD_SET_BIT) |=> net_fail_reg ##1 dout_reg == $past(
      (mode_reg == `MODE_HIGH) ? {OUT_WIDTH{1'b1}} :
      (mode_reg == `MODE_LOW) ? {OUT_WIDTH{1'b0}} : dout_reg);
  endproperty
  a_force: assert property (p_force)
    else $error("forced failure not applied");

  property p_ack;
    (s_cmd(`CMD_ACK_BIT) and (net_fail_reg && !fail_any)) |=>
      !net_fail_reg && elapsed_reg == 16'h0000;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not clear failure");

  property p_status;
    summary_status[`ST_ERROR_BIT] ==
      (net_fail_reg || diag_status != 16'h0000);
  endproperty
  a_status: assert property (p_status)
    else $error("error summary wrong");

  property p_no_stop;
    active |=> active;
  endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("watchdog stopped after activation");

  property p_trigger;
    (active && pd_wr) |=> elapsed_reg == 16'h0000 && !tick;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("output write did not restart watchdog");
endmodule

// >>> verification/modbus_client_model.sv
// remote client model issuing register accesses and output data writes
`timescale 1ns/1ps
module modbus_client_model (
  input wire logic clk,
  output logic reg_req,
  output logic reg_we,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_exc,
  output logic pd_wr,
  output logic [15:0] pd_wdata
);
  logic [15:0] rd_last;
  logic exc_last;
  logic ack_last;
  initial begin
    reg_req = 1'b0;
    reg_we = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    pd_wr = 1'b0;
    pd_wdata = 16'h0000;
  end
  // callers pass one-hot command words and legal timeouts unless a refusal
  // is the point of the access
  task automatic access(input logic we, input logic [15:0] addr,
                        input logic [15:0] wdata);
    @(negedge clk);
    reg_req = 1'b1;
    reg_we = we;
    reg_addr = addr;
    reg_wdata = wdata;
    @(negedge clk);
    // the answer stands for one cycle only, so take it before releasing
    ack_last = reg_ack;
    exc_last = reg_exc;
    rd_last = reg_rdata;
    reg_req = 1'b0;
    // released lines flip so a stale value can never pass for a live one
    reg_we = ~we;
    reg_addr = ~addr;
    reg_wdata = ~wdata;
  endtask
  // each call retriggers the supervision period once the watchdog runs; with a nonzero timeout the first call only starts it
  task automatic pd_write(input logic [15:0] d);
    @(negedge clk);
    pd_wr = 1'b1;
    pd_wdata = d;
    @(negedge clk);
    pd_wr = 1'b0;
    pd_wdata = ~d;
  endtask
endmodule

// >>> verification/process_watchdog_fault_registers_bench.sv
// self-checking bench for the process data watchdog and fault registers
`timescale 1ns/1ps
`include "wdog_map.svh"
module process_watchdog_fault_registers_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ack_manual = 1'b0;
  logic [4:0] src = 5'h00;
  logic [4:0] pins = 5'h00;
  logic reg_req, reg_we, reg_ack, reg_exc, pd_wr, net_fail, cmd_error;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, pd_wdata, dout, d, w;
  int fails = 0;
  int n_tests = 0;
  int seed = 51;
  int k;
  logic [15:0] codes [5] = '{16'h000d, 16'h000a, 16'h000b, 16'h0007, 16'h0008};
  logic [15:0] dbit [5] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010, 16'h0400};
  always #5 clk = ~clk;
  modbus_client_model i_c (.clk(clk), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_exc(reg_exc), .pd_wr(pd_wr),
    .pd_wdata(pd_wdata));
  process_watchdog #(.CYCLES_PER_MS(10), .OUT_WIDTH(16)) i_dut (.clk(clk),
    .resetn(resetn), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_exc(reg_exc), .pd_wr(pd_wr),
    .pd_wdata(pd_wdata), .ack_manual(ack_manual), .conn_timeout(src[0]),
    .conn_abort(src[1]), .init_error(src[2]),
    .internal_link_timeout(src[3]), .host_timeout(src[4]),
    .out_overload_pin(pins[0]), .sens_undervolt_pin(pins[1]),
    .sens_surge_pin(pins[2]), .sens_short_pin(pins[3]),
    .over_temp_pin(pins[4]), .dout(dout), .net_fail(net_fail),
    .cmd_error(cmd_error));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp,
                    input logic exc = 1'b0);
    i_c.access(1'b0, a, 16'h0000);
    chk({15'h0000, i_c.ack_last}, 16'h0001);
    chk({15'h0000, i_c.exc_last}, {15'h0000, exc});
    chk(i_c.rd_last, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v,
                    input logic exc);
    i_c.access(1'b1, a, v);
    chk({15'h0000, i_c.ack_last}, 16'h0001);
    chk({15'h0000, i_c.exc_last}, {15'h0000, exc});
  endtask
  function automatic logic [15:0] subst(input int m, input logic [15:0] v);
    if (m == 0) return 16'h0000;
    if (m == 1) return 16'hffff;
    return v;
  endfunction
  // bounded wait for the link failure flag, up to 60 cycles, about twice the 30 or so needed
  task automatic wait_fail;
    for (k = 0; k < 60 && net_fail !== 1'b1; k++) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    $display("ERROR %0t: run did not complete", $time);
    tally_and_finish;
  end
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    rd(`TIMEOUT_ADDR, 16'h0000);
    rd(`MODE_ADDR, 16'h0000);
    rd(`REASON_ADDR, 16'h0000);
    rd(`STATUS_ADDR, 16'h0000);
    rd(`DIAG_ADDR, 16'h0000);
    rd(`CMD_ADDR, 16'h0000, 1'b1);
    wr(`REASON_ADDR, 16'h1234, 1'b1);
    wr(`STATUS_ADDR, 16'h0003, 1'b1);
    wr(16'h0100, 16'h0001, 1'b1);
    rd(`REASON_ADDR, 16'h0000);
    wr(`TIMEOUT_ADDR, 16'd199, 1'b1);
    wr(`TIMEOUT_ADDR, 16'd65001, 1'b1);
    wr(`TIMEOUT_ADDR, 16'd65000, 1'b0);
    rd(`TIMEOUT_ADDR, 16'd65000);
    wr(`TIMEOUT_ADDR, 16'h0000, 1'b0);
    wr(`MODE_ADDR, 16'h0003, 1'b1);
    $display("test done: reset values and access kinds");
    for (int m = 0; m < 3; m++) begin
      d = $random(seed);
      ack_manual = (m == 1);
      i_c.pd_write(d);
      wr(`MODE_ADDR, m[15:0], 1'b0);
      rd(`MODE_ADDR, m[15:0]);
      wr(`CMD_ADDR, 16'h0010, 1'b0);
      chk(net_fail, 1'b1);
      rd(`REASON_ADDR, `REASON_USER);
      rd(`STATUS_ADDR, 16'h0003);
      chk(dout, subst(m, d));
      if (m == 1) begin
        d = $random(seed);
        i_c.pd_write(d);
        chk(net_fail, 1'b1);
      end
      wr(`CMD_ADDR, 16'h0020, 1'b0);
      chk(net_fail, 1'b0);
      @(negedge clk);
      chk(dout, d);
      rd(`STATUS_ADDR, 16'h0000);
    end
    ack_manual = 1'b0;
    $display("test done: fault response modes");
    wr(`CMD_ADDR, 16'h0001, 1'b0);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      w = w | (16'h0101 << i);
      wr(`CMD_ADDR, w, 1'b1);
      chk(cmd_error, 1'b1);
      chk(net_fail, 1'b0);
    end
    wr(`CMD_ADDR, 16'h0030, 1'b1);
    chk(net_fail, 1'b0);
    $display("test done: command word checks");
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      src[i] = 1'b1;
      @(negedge clk);
      src = 5'h00;
      @(negedge clk);
      chk(net_fail, 1'b1);
      rd(`REASON_ADDR, codes[i]);
      wr(`CMD_ADDR, 16'h0020, 1'b0);
    end
    $display("test done: failure sources");
    for (int i = 0; i < 5; i++) begin
      pins[i] = 1'b1;
      repeat (4) @(negedge clk);
      rd(`DIAG_ADDR, dbit[i]);
      rd(`STATUS_ADDR, 16'h0001);
      pins[i] = 1'b0;
      repeat (4) @(negedge clk);
      // supply undervoltage and overtemperature follow their pins
      rd(`DIAG_ADDR, (i == 1 || i == 4) ? 16'h0000 : dbit[i]);
      wr(`CMD_ADDR, 16'h0080, 1'b0);
      rd(`DIAG_ADDR, 16'h0000);
    end
    $display("test done: diagnostics");
    wr(`MODE_ADDR, 16'h0001, 1'b0);
    wr(`TIMEOUT_ADDR, 16'd200, 1'b0);
    repeat (3000) @(negedge clk);
    chk(net_fail, 1'b0);
    d = $random(seed);
    i_c.pd_write(d);
    repeat (2) begin
      repeat (1500) @(negedge clk);
      i_c.pd_write(d);
    end
    wr(`TIMEOUT_ADDR, 16'h0000, 1'b1);
    // reads alone must not keep the period alive
    for (int i = 0; i < 984; i++) rd(`STATUS_ADDR, 16'h0000);
    wait_fail;
    chk(net_fail, 1'b1);
    rd(`REASON_ADDR, `REASON_WDOG);
    chk(dout, 16'hffff);
    i_c.pd_write(d);
    @(negedge clk);
    chk(net_fail, 1'b0);
    repeat (1970) @(negedge clk);
    chk(net_fail, 1'b0);
    wait_fail;
    chk(net_fail, 1'b1);
    $display("test done: watchdog supervision");
    tally_and_finish;
  end
endmodule
